/* logic/oms_core.sv */
// sample sequencer for two time slots: pulsing, conversion, averaging
`timescale 1ns/1ps
`default_nettype none
// How it works
// - eight-bit pulse count per slot per sample
// - three-bit field selects summed internal sample run
// - output rate is internal rate over run
// - power value 0x38 leaves only channel one
// - front-end value 0xb065 selects direct conversion
// - direct mode converts four channels, one per microsecond
// - direct codes stay raw, dark near 13000
// - each slot picks its mode independently
// - all channel results of a slot update together
module oms_core
   import oms_pkg::*;
(
   input  wire logic                         clock_i,
   input  wire logic                         rst_b_i,
   input  wire logic                         sample_tick_i,
   input  wire logic [oms_pkg::PCNT_W-1:0]   slot_a_pulse_count_i,
   input  wire logic [oms_pkg::PCNT_W-1:0]   slot_b_pulse_count_i,
   input  wire logic [oms_pkg::AVG_W-1:0]    slot_a_avg_sel_i,
   input  wire logic [oms_pkg::AVG_W-1:0]    slot_b_avg_sel_i,
   input  wire logic [oms_pkg::PWR_W-1:0]    power_cfg_i,
   input  wire logic [oms_pkg::FE_CFG_W-1:0] slot_a_fe_cfg_i,
   input  wire logic [oms_pkg::FE_CFG_W-1:0] slot_b_fe_cfg_i,
   input  wire logic                         slot_a_group_i,
   input  wire logic                         slot_b_group_i,
   input  wire logic [oms_pkg::WIDTH_W-1:0]  slot_a_emitter_width_i,
   input  wire logic [oms_pkg::WIDTH_W-1:0]  slot_b_emitter_width_i,
   input  wire logic [oms_pkg::ADC_W-1:0]    adc_data_i,
   output logic                              adc_start_o,
   output logic      [2:0]                   adc_chan_o,
   output logic                              emitter_a_o,
   output logic                              emitter_b_o,
   output logic                              fe_bypass_o,
   output logic      [oms_pkg::NUM_CH-1:0]   chan_power_o,
   output logic                              busy_o,
   output logic                              direct_conversion_mode_o,
   output logic      [oms_pkg::RES_W-1:0]    slot_a_result_o,
   output logic      [oms_pkg::RES_W-1:0]    slot_b_result_o,
   output logic                              fifo_valid_o,
   input  wire logic                         fifo_ready_i,
   output logic      [oms_pkg::FIFO_W-1:0]   fifo_data_o
);
   // ==========================================================
   // per-slot views of the configuration ports
   logic [PCNT_W-1:0]   pcnt   [NUM_SLOTS];
   logic [AVG_W-1:0]    avgsel [NUM_SLOTS];
   logic [WIDTH_W-1:0]  width  [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] direct, group;

   assign pcnt[0]   = slot_a_pulse_count_i;
   assign pcnt[1]   = slot_b_pulse_count_i;
   assign avgsel[0] = slot_a_avg_sel_i;
   assign avgsel[1] = slot_b_avg_sel_i;
   assign width[0]  = slot_a_emitter_width_i;
   assign width[1]  = slot_b_emitter_width_i;
   assign group     = {slot_b_group_i, slot_a_group_i};
   // mode decoded per slot, so one slot may pulse while the other
   // runs direct conversion
   assign direct[0] = (slot_a_fe_cfg_i == FE_DIRECT);
   assign direct[1] = (slot_b_fe_cfg_i == FE_DIRECT);

   // ==========================================================
   // channel power
   always_comb begin
      if (power_cfg_i == PWR_SINGLE) begin
         chan_power_o = CH_ONLY_FIRST;
      end else begin
         chan_power_o = CH_ALL;
      end
   end

   // ==========================================================
   // sequencer state
   oms_state_t                        st_reg, st_next;
   logic                              slot_reg, slot_next;
   logic [1:0]                        ch_reg, ch_next;
   logic [PCNT_W-1:0]                 pulse_reg, pulse_next;
   logic [WIDTH_W-1:0]                wcnt_reg, wcnt_next;
   logic [US_CNT_W-1:0]               us_reg, us_next;
   logic [NUM_CH-1:0][PULSE_ACC_W-1:0] acc_reg, acc_next;
   logic [RES_W-1:0]                  res_reg [NUM_SLOTS];
   logic [RES_W-1:0]                  res_next [NUM_SLOTS];

   logic                  us_tick, cur_direct, slot_active, last_pulse;
   logic [PULSE_ACC_W-1:0] sample;
   logic [NUM_SLOTS-1:0]  avg_in_valid, avg_out_valid;
   logic [RES_W-1:0]      avg_out [NUM_SLOTS];
   logic                  fifo_in_ready, push;

   assign us_tick     = (us_reg == US_CNT_W'(CONV_SPACING_CYC - 1));
   assign cur_direct  = direct[slot_reg];
   // a pulsed slot with zero pulses is treated as switched off
   assign slot_active = cur_direct || (pcnt[slot_reg] != '0);
   assign last_pulse  = (pulse_reg == pcnt[slot_reg] - 1'b1);
   // powered-down channels contribute nothing; direct codes are
   // stored as converted, so more light gives fewer codes
   assign sample = chan_power_o[ch_reg] ?
      PULSE_ACC_W'(adc_data_i) : '0;

   assign adc_start_o = (st_reg == ST_CONV) && (us_reg == '0);
   assign adc_chan_o  = {group[slot_reg], ch_reg};
   assign emitter_a_o = (st_reg == ST_EMIT) && !slot_reg;
   assign emitter_b_o = (st_reg == ST_EMIT) && slot_reg;
   assign fe_bypass_o = (st_reg != ST_IDLE) && cur_direct;
   assign busy_o      = (st_reg != ST_IDLE);
   assign direct_conversion_mode_o = cur_direct;

   always_comb begin
      st_next    = st_reg;
      slot_next  = slot_reg;
      ch_next    = ch_reg;
      pulse_next = pulse_reg;
      wcnt_next  = wcnt_reg;
      us_next    = us_reg;
      acc_next   = acc_reg;
      case (st_reg)
         ST_IDLE: begin
            // ticks that land while a sample is running are dropped
            if (sample_tick_i) begin
               slot_next = 1'b0;
               st_next   = ST_LAUNCH;
            end
         end
         ST_LAUNCH: begin
            acc_next   = '0;
            pulse_next = '0;
            ch_next    = '0;
            wcnt_next  = '0;
            us_next    = '0;
            if (!slot_active) begin
               if (!slot_reg) begin
                  slot_next = 1'b1;
               end else begin
                  st_next = ST_IDLE;
               end
            end else if (cur_direct) begin
               st_next = ST_CONV;
            end else begin
               st_next = ST_EMIT;
            end
         end
         ST_EMIT: begin
            us_next = us_tick ? '0 : us_reg + 1'b1;
            if (us_tick) begin
               wcnt_next = wcnt_reg + 1'b1;
               // a zero width still lights the emitter for 1 us
               if (wcnt_reg >= width[slot_reg] - 1'b1 ||
                   width[slot_reg] == '0) begin
                  st_next = ST_CONV;
                  ch_next = '0;
               end
            end
         end
         ST_CONV: begin
            us_next = us_tick ? '0 : us_reg + 1'b1;
            if (us_tick) begin
               if (cur_direct) begin
                  acc_next[ch_reg] = sample;
               end else begin
                  acc_next[ch_reg] = acc_reg[ch_reg] + sample;
               end
               ch_next = ch_reg + 1'b1;
               if (ch_reg == 2'(NUM_CH - 1)) begin
                  if (cur_direct || last_pulse) begin
                     st_next = ST_PASS;
                  end else begin
                     pulse_next = pulse_reg + 1'b1;
                     wcnt_next  = '0;
                     st_next    = ST_EMIT;
                  end
               end
            end
         end
         ST_PASS: begin
            // waits here while the fifo is full, holding the sample
            if (fifo_in_ready) begin
               if (!slot_reg) begin
                  slot_next = 1'b1;
                  st_next   = ST_LAUNCH;
               end else begin
                  st_next = ST_IDLE;
               end
            end
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg    <= ST_IDLE;
         slot_reg  <= 1'b0;
         ch_reg    <= '0;
         pulse_reg <= '0;
         wcnt_reg  <= '0;
         us_reg    <= '0;
         acc_reg   <= '0;
      end else begin
         st_reg    <= st_next;
         slot_reg  <= slot_next;
         ch_reg    <= ch_next;
         pulse_reg <= pulse_next;
         wcnt_reg  <= wcnt_next;
         us_reg    <= us_next;
         acc_reg   <= acc_next;
      end
   end

   // ==========================================================
   // averaging per slot
   genvar s;
   generate
      for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
         assign avg_in_valid[s] = (st_reg == ST_PASS) && fifo_in_ready &&
                                  (slot_reg == 1'(s));
         oms_avg u_avg (
            .clock_i     (clock_i),
            .rst_b_i     (rst_b_i),
            .in_valid_i  (avg_in_valid[s]),
            .in_data_i   (acc_reg),
            .sel_i       (avgsel[s]),
            .out_valid_o (avg_out_valid[s]),
            .out_data_o  (avg_out[s])
         );
      end
   endgenerate

   // ==========================================================
   // result registers and output stream
   assign push = |avg_out_valid;

   always_comb begin
      res_next = res_reg;
      for (int i = 0; i < NUM_SLOTS; i++) begin
         if (avg_out_valid[i]) begin
            // every channel of the slot is written in the same edge
            res_next[i] = avg_out[i];
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            res_reg[i] <= '0;
         end
      end else begin
         res_reg <= res_next;
      end
   end

   assign slot_a_result_o = res_reg[0];
   assign slot_b_result_o = res_reg[1];

   oms_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock_i     (clock_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   ({slot_reg, avg_out[slot_reg]}),
      .out_valid_o (fifo_valid_o),
      .out_ready_i (fifo_ready_i),
      .out_data_o  (fifo_data_o)
   );

   // ==========================================================
   // checks
   // cycles since the last conversion start; saturates so a long
   // emit window cannot wrap it back into range
   logic [US_CNT_W-1:0] gap_reg, gap_next;
   always_comb begin
      gap_next = gap_reg;
      if (adc_start_o) begin
         gap_next = '0;
      end else if (gap_reg != '1) begin
         gap_next = gap_reg + 1'b1;
      end
   end
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gap_reg <= '0;
      end else begin
         gap_reg <= gap_next;
      end
   end
   chk_single_channel: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      power_cfg_i == PWR_SINGLE |-> chan_power_o == CH_ONLY_FIRST)
      else $error("single channel mode left channels powered");
   chk_all_channels: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      power_cfg_i != PWR_SINGLE |-> chan_power_o == CH_ALL)
      else $error("channels powered down without single mode");
   chk_bypass_per_slot: assert property (@(posedge clock_i)
      disable iff (!rst_b_i) st_reg != ST_IDLE |-> fe_bypass_o ==
      (slot_reg ? slot_b_fe_cfg_i == FE_DIRECT
                : slot_a_fe_cfg_i == FE_DIRECT))
      else $error("bypass does not follow the active slot");
   chk_conv_spacing: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      adc_start_o && ch_reg != 2'd3 |-> ##50 (adc_start_o &&
      gap_reg == US_CNT_W'(CONV_SPACING_CYC - 1) &&
      adc_chan_o[1:0] == $past(adc_chan_o[1:0], 50) + 2'd1))
      else $error("channel conversions not 1 us apart in order");
   chk_pulse_count: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      st_reg == ST_CONV && st_next == ST_PASS && !cur_direct |->
      pulse_reg == pcnt[slot_reg] - 8'd1)
      else $error("pulse count per sample wrong");
   chk_result_together: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      avg_out_valid[0] |=> slot_a_result_o == $past(avg_out[0]))
      else $error("slot a result not updated on output");
   chk_stall_full: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      st_reg == ST_PASS && !fifo_in_ready |-> !push ##1 st_reg == ST_PASS)
      else $error("output emitted while stream is full");
endmodule
`default_nettype wire

/* logic/oms_pkg.sv */
// shared constants and types of the optical sample mode block
package oms_pkg;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS   = 20;
   localparam int CONV_SPACING_NS = 1000;
   localparam int CONV_SPACING_CYC = (CONV_SPACING_NS / CLK_PERIOD_NS < 1) ?
      1 : CONV_SPACING_NS / CLK_PERIOD_NS;
   localparam int US_CNT_W        = 6;
   // ==========================================================
   // widths
   localparam int NUM_CH      = 4;
   localparam int NUM_SLOTS   = 2;
   localparam int PCNT_W      = 8;
   localparam int AVG_W       = 3;
   localparam int AVG_CNT_W   = 7;
   localparam int PWR_W       = 6;
   localparam int FE_CFG_W    = 16;
   localparam int ADC_W       = 14;
   localparam int WIDTH_W     = 5;
   // one pulse adds at most a full-scale code, up to 255 pulses
   localparam int PULSE_ACC_W = PCNT_W + ADC_W;
   // up to 128 internal samples summed per output sample
   localparam int SUM_W       = PULSE_ACC_W + AVG_CNT_W;
   localparam int RES_W       = NUM_CH * SUM_W;
   localparam int FIFO_W      = RES_W + 1;
   localparam int FIFO_DEPTH  = 32;
   // ==========================================================
   // field values
   localparam logic [PWR_W-1:0]    PWR_SINGLE   = 6'h38;
   localparam logic [PWR_W-1:0]    PWR_ALL      = 6'h00;
   localparam logic [FE_CFG_W-1:0] FE_DIRECT    = 16'hb065;
   localparam logic [NUM_CH-1:0]   CH_ONLY_FIRST = 4'h1;
   localparam logic [NUM_CH-1:0]   CH_ALL        = 4'hf;
   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LAUNCH,
      ST_EMIT,
      ST_CONV,
      ST_PASS
   } oms_state_t;
endpackage

/* logic/oms_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module oms_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clock_i,
   input  wire logic             rst_b_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
   logic             full, empty, push, pop;

   // ==========================================================
   // pointers carry one extra wrap bit to tell full from empty
   assign empty       = (wr_reg == rd_reg);
   assign full        = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) &&
                        (wr_reg[AW] != rd_reg[AW]);
   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = mem_reg[rd_reg[AW-1:0]];
   assign push        = in_valid_i && !full;
   assign pop         = out_ready_i && !empty;

   always_comb begin
      mem_next = mem_reg;
      wr_next  = wr_reg;
      rd_next  = rd_reg;
      if (push) begin
         mem_next[wr_reg[AW-1:0]] = in_data_i;
         wr_next = wr_reg + 1'b1;
      end
      if (pop) begin
         rd_next = rd_reg + 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         mem_reg <= mem_next;
      end
   end

   chk_fifo_full_stall: assert property (@(posedge clock_i)
      disable iff (!rst_b_i) full |-> !in_ready_o ##1 $stable(wr_reg))
      else $error("fifo accepted a word while full");
endmodule
`default_nettype wire

/* logic/oms_avg.sv */
// per-slot accumulator that sums a selectable run of internal samples
`timescale 1ns/1ps
`default_nettype none
module oms_avg
   import oms_pkg::*;
(
   input  wire logic                          clock_i,
   input  wire logic                          rst_b_i,
   input  wire logic                          in_valid_i,
   input  wire logic [NUM_CH*PULSE_ACC_W-1:0] in_data_i,
   input  wire logic [oms_pkg::AVG_W-1:0]     sel_i,
   output logic                               out_valid_o,
   output logic      [oms_pkg::RES_W-1:0]     out_data_o
);
   logic [AVG_CNT_W-1:0] cnt_reg, cnt_next, target;
   logic [RES_W-1:0]     acc_reg, acc_next, sum;

   // sel picks 1, 2, 4 ... 128 internal samples per output
   assign target      = AVG_CNT_W'((8'h01 << sel_i) - 8'h01);
   // a shrinking selection mid-run must not strand the counter
   assign out_valid_o = in_valid_i && (cnt_reg >= target);
   assign out_data_o  = sum;

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_ch
         assign sum[c*SUM_W +: SUM_W] = acc_reg[c*SUM_W +: SUM_W] +
            SUM_W'(in_data_i[c*PULSE_ACC_W +: PULSE_ACC_W]);
      end
   endgenerate

   always_comb begin
      cnt_next = cnt_reg;
      acc_next = acc_reg;
      if (out_valid_o) begin
         // fresh start for the next output sample
         cnt_next = '0;
         acc_next = '0;
      end else if (in_valid_i) begin
         cnt_next = cnt_reg + 1'b1;
         acc_next = sum;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_reg <= '0;
         acc_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
         acc_reg <= acc_next;
      end
   end

   chk_avg_clear_after: assert property (@(posedge clock_i)
      disable iff (!rst_b_i) out_valid_o |=> cnt_reg == '0 && acc_reg == '0)
      else $error("accumulator not cleared after output");
   chk_avg_run_length: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      in_valid_i && !out_valid_o |=> cnt_reg == $past(cnt_reg) + 1'b1)
      else $error("internal sample not counted");
endmodule
`default_nettype wire

/* testbench/oms_adc_model.sv */
// converter and photodiode stand-in facing the sample sequencer
`timescale 1ns/1ps
`default_nettype none
module oms_adc_model (
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   input  wire logic        adc_start_i,
   input  wire logic [2:0]  adc_chan_i,
   input  wire logic        busy_i,
   input  wire logic [13:0] light_i,
   output logic      [13:0] adc_data_o
);
   logic [2:0]  chan_reg;
   logic [13:0] junk_reg;
   // ==========================================================
   // channel latch
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         chan_reg <= 3'h0;
         junk_reg <= 14'h1555;
      end else begin
         junk_reg <= ~junk_reg + 14'h0003;
         if (adc_start_i) begin
            chan_reg <= adc_chan_i;
         end
      end
   end
   // dark reads high, light pulls it down; idle shows a moving pattern
   assign adc_data_o = busy_i ?
      14'h32c8 - light_i - {7'h00, chan_reg, 4'h0} : junk_reg;
endmodule
`default_nettype wire

/* testbench/optical_sample_mode_config_tb_top.sv */
// self-checking bench of the optical sample sequencer
`timescale 1ns/1ps
`default_nettype none
module optical_sample_mode_config_tb_top;
   import oms_pkg::*;
   logic                clock_i = 1'b0;
   logic                rst_b_i = 1'b0;
   logic                tick    = 1'b0;
   logic [PCNT_W-1:0]   pc_a    = 8'h00;
   logic [PCNT_W-1:0]   pc_b    = 8'h00;
   logic [AVG_W-1:0]    sel_a   = 3'h0;
   logic [AVG_W-1:0]    sel_b   = 3'h0;
   logic [PWR_W-1:0]    pwr     = 6'h00;
   logic [FE_CFG_W-1:0] fe_a    = 16'h0000;
   logic [FE_CFG_W-1:0] fe_b    = 16'h0000;
   logic                grp_a   = 1'b0;
   logic                grp_b   = 1'b0;
   logic [WIDTH_W-1:0]  ew_a    = 5'h01;
   logic [WIDTH_W-1:0]  ew_b    = 5'h02;
   logic [13:0]         light   = 14'h0000;
   logic                rdy     = 1'b1;
   logic [1:0]          rmode   = 2'h0;
   logic [15:0]         rnd     = 16'hb77c;
   logic [ADC_W-1:0]    adc_d;
   logic                adc_st, em_a, em_b, busy, fval, byp, dcm;
   logic [2:0]          adc_ch;
   logic [NUM_CH-1:0]   chpow;
   logic [RES_W-1:0]    res_a, res_b;
   logic [FIFO_W-1:0]   fdata;
   logic [FIFO_W-1:0]   exp_q[$];
   logic [FIFO_W-1:0]   last_w[2] = '{default: '0};
   longint              acc[2][4] = '{default: 0};
   int                  n_acc[2]  = '{default: 0};
   int                  error_cnt = 0;
   int                  num_checks = 0;
   int                  ecnt = 0;
   int                  ecnt_b = 0;
   int                  cyc = 0;
   int                  last_st = 0;
   logic [2:0]          last_ch = 3'h0;

   always #10 clock_i = ~clock_i;

   oms_core oms_core_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .sample_tick_i(tick), .slot_a_pulse_count_i(pc_a),
      .slot_b_pulse_count_i(pc_b), .slot_a_avg_sel_i(sel_a),
      .slot_b_avg_sel_i(sel_b), .power_cfg_i(pwr),
      .slot_a_fe_cfg_i(fe_a), .slot_b_fe_cfg_i(fe_b),
      .slot_a_group_i(grp_a), .slot_b_group_i(grp_b),
      .slot_a_emitter_width_i(ew_a), .slot_b_emitter_width_i(ew_b),
      .adc_data_i(adc_d), .adc_start_o(adc_st), .adc_chan_o(adc_ch),
      .emitter_a_o(em_a), .emitter_b_o(em_b), .fe_bypass_o(byp),
      .chan_power_o(chpow), .busy_o(busy),
      .direct_conversion_mode_o(dcm), .slot_a_result_o(res_a),
      .slot_b_result_o(res_b), .fifo_valid_o(fval),
      .fifo_ready_i(rdy), .fifo_data_o(fdata));

   oms_adc_model oms_adc_model_inst (.clock_i(clock_i),
      .rst_b_i(rst_b_i), .adc_start_i(adc_st), .adc_chan_i(adc_ch),
      .busy_i(busy), .light_i(light), .adc_data_o(adc_d));

   // ==========================================================
   // comparison, reference model and drivers
   function automatic logic [15:0] lfsr_step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic check(input logic [FIFO_W-1:0] got, exp,
                        input string what);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic ref_slot(input int s);
      logic [FIFO_W-1:0] w;
      int                p;
      int                c;
      bit                dir;
      dir = ((s != 0) ? fe_b : fe_a) === FE_DIRECT;
      p = (s != 0) ? pc_b : pc_a;
      if (!dir && p == 0) return;
      for (int ch = 0; ch < 4; ch++) begin
         c = 13000 - light - (((s != 0) ? grp_b : grp_a) * 4 + ch) * 16;
         if (pwr === PWR_SINGLE && ch > 0) c = 0;
         acc[s][ch] += dir ? c : c * p;
      end
      n_acc[s]++;
      // a run shortened mid-way closes on the next sample
      if (n_acc[s] >= (1 << ((s != 0) ? sel_b : sel_a))) begin
         w[FIFO_W-1] = (s != 0);
         for (int ch = 0; ch < 4; ch++) begin
            w[ch*SUM_W +: SUM_W] = acc[s][ch][SUM_W-1:0];
            acc[s][ch] = 0;
         end
         n_acc[s] = 0;
         exp_q.push_back(w);
         last_w[s] = w;
      end
   endtask

   task automatic settle(input string name);
      int n;
      n = 0;
      while ((busy !== 1'b0 || exp_q.size() != 0) && n < 30000) begin
         @(negedge clock_i);
         n++;
      end
      check(n < 30000, 1'b1, "hang");
      check(res_a, last_w[0][RES_W-1:0], "slot a result");
      check(res_b, last_w[1][RES_W-1:0], "slot b result");
      $display("test %s done", name);
   endtask

   task automatic do_tick;
      int n;
      n = 0;
      // config written at the last edge must land before the model reads it
      @(negedge clock_i);
      while (busy !== 1'b0 && n < 30000) begin
         @(negedge clock_i);
         n++;
      end
      ref_slot(0);
      ref_slot(1);
      @(posedge clock_i);
      tick <= 1'b1;
      @(posedge clock_i);
      tick <= 1'b0;
      repeat (2) @(posedge clock_i);
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // monitors
   always @(posedge clock_i) begin
      rnd <= lfsr_step(rnd);
      rdy <= (rmode == 2'h0) | ((rmode == 2'h1) & rnd[3]);
      cyc <= cyc + 1;
      if (fval && rdy) begin
         if (exp_q.size() == 0) check(1'b1, 1'b0, "extra word");
         else check(fdata, exp_q.pop_front(), "stream word");
      end
      if (em_a) ecnt <= ecnt + 1;
      else if (ecnt != 0) begin
         check(ecnt, ((ew_a == 0) ? 1 : ew_a) * 50, "emit width");
         ecnt <= 0;
      end
      if (em_b) ecnt_b <= ecnt_b + 1;
      else if (ecnt_b != 0) begin
         check(ecnt_b, ((ew_b == 0) ? 1 : ew_b) * 50, "emit b width");
         ecnt_b <= 0;
      end
      if (em_a || em_b) check({byp, dcm}, 2'h0, "bypass pulsed");
      if (adc_st && fe_a === FE_DIRECT && fe_b === FE_DIRECT)
         check({byp, dcm}, 2'h3, "bypass direct");
      if (adc_st) begin
         if (adc_ch[1:0] != 2'h0) begin
            check(cyc - last_st, 50, "conv spacing");
            check(adc_ch, last_ch + 3'h1, "conv order");
         end
         last_st <= cyc;
         last_ch <= adc_ch;
      end
   end

   initial begin
      #2_000_000;
      error_cnt++;
      $display("BAD t=%0t watchdog expired", $time);
      give_verdict();
   end

   // ==========================================================
   // scenarios
   initial begin
      repeat (10) @(posedge clock_i);
      rst_b_i <= 1'b1;
      @(posedge clock_i);
      fe_a <= FE_DIRECT;
      fe_b <= FE_DIRECT;
      repeat (2) do_tick();
      settle("direct dark");
      check(chpow, CH_ALL, "all powered");
      fe_a <= 16'h0000;
      fe_b <= 16'h0000;
      pc_a <= 8'h03;
      sel_a <= 3'h2;
      light <= 14'h01f4;
      // tick rate raised by the summing factor keeps output rate
      repeat (8) do_tick();
      settle("pulsed summing");
      fe_a <= FE_DIRECT;
      pc_b <= 8'h02;
      sel_b <= 3'h1;
      grp_b <= 1'b1;
      pwr <= PWR_SINGLE;
      repeat (2) do_tick();
      settle("mixed single channel");
      check(chpow, CH_ONLY_FIRST, "one powered");
      rmode <= 2'h1;
      repeat (6) begin
         @(posedge clock_i);
         light <= {4'h0, rnd[9:0]};
         pc_a <= {6'h00, rnd[1:0]} + 8'h01;
         pc_b <= {6'h00, rnd[3:2]} + 8'h01;
         sel_a <= {2'h0, rnd[4]};
         sel_b <= {2'h0, rnd[5]};
         fe_a <= rnd[6] ? FE_DIRECT : 16'h0000;
         fe_b <= rnd[7] ? FE_DIRECT : 16'h0000;
         grp_a <= rnd[8];
         grp_b <= rnd[9];
         pwr <= rnd[10] ? PWR_SINGLE : PWR_ALL;
         ew_a <= {3'h0, rnd[12:11]};
         repeat (2) do_tick();
         settle("random");
      end
      rmode <= 2'h2;
      fe_a <= FE_DIRECT;
      sel_a <= 3'h0;
      pc_b <= 8'h00;
      fe_b <= 16'h0000;
      repeat (FIFO_DEPTH + 1) do_tick();
      repeat (300) @(posedge clock_i);
      check(busy, 1'b1, "full stall");
      check(fval, 1'b1, "full valid");
      rmode <= 2'h0;
      settle("fifo full");
      give_verdict();
   end
endmodule
`default_nettype wire
